// [xphc_defines.svh]
`ifndef XPHC_DEFINES_SVH
`define XPHC_DEFINES_SVH
`define XPHC_PTI_CALL      8'h0B
`define XPHC_PTI_CALL_ACC  8'h0F
`define XPHC_PTI_CLR       8'h13
`define XPHC_PTI_CLR_CONF  8'h17
`define XPHC_PTI_RST       8'h1B
`define XPHC_PTI_RST_CONF  8'h1F
`define XPHC_PTI_RSTRT     8'hFB
`define XPHC_PTI_RSTRT_CNF 8'hFF
`define XPHC_PTI_DIAG      8'hF1
`define XPHC_PTI_RR128     8'h01
`define XPHC_PTI_RNR128    8'h05
`define XPHC_RR8_LOW       5'h01
`define XPHC_RNR8_LOW      5'h05
`define XPHC_DIAG_BAD_DBIT 8'hE9
`define XPHC_LCI_NONE      12'h000
`define XPHC_GFI_Q         7
`define XPHC_GFI_D         6
`define XPHC_GFI_M128      5
`define XPHC_GFI_M8        4
`define XPHC_ADDR_CTRL     4'h0
`define XPHC_ADDR_STAT     4'h4
`define XPHC_ADDR_RXCNT    4'h8
`define XPHC_CTRL_MOD128   0
`define XPHC_CTRL_LLC_LO   1
`define XPHC_CTRL_SVC      3
`define XPHC_CTRL_LCI_LO   16
`define XPHC_LLC_QUAL      2'h0
`define XPHC_LLC_ENH       2'h1
`define XPHC_LLC_HDRSVC    2'h2
`define XPHC_ST_DBIT       0
`define XPHC_ST_BADTYPE    1
`define XPHC_ST_BADLCI     2
`define XPHC_ST_SHORT      3
`define XPHC_ST_TXREF      4
`define XPHC_ST_PTI_LO     8
`endif

// [xphc_pkg.sv]
`default_nettype none
package xphc_pkg;
	typedef enum logic [3:0] {
		K_DATA = 4'h0, K_RR = 4'h1, K_RNR = 4'h2, K_CALL = 4'h3,
		K_CALL_ACC = 4'h4, K_CLR = 4'h5, K_CLR_CONF = 4'h6, K_RST = 4'h7,
		K_RST_CONF = 4'h8, K_RSTRT = 4'h9, K_RSTRT_CNF = 4'hA, K_DIAG = 4'hB,
		K_BAD = 4'hF
	} xphc_kind_t;
	typedef enum logic [1:0] {S_IDLE = 2'h0, S_HDR = 2'h1, S_PAY = 2'h2} xphc_state_t;
	typedef struct packed {
		xphc_kind_t kind;
		logic [6:0] ps;
		logic [6:0] pr;
		logic       more;
		logic       qual;
		logic [7:0] cause;
		logic [7:0] diag;
	} xphc_tx_req_t;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} xphc_byte_t;
	typedef struct packed {
		xphc_kind_t  kind;
		logic [11:0] lci;
		logic [6:0]  ps;
		logic [6:0]  pr;
		logic        more;
		logic        qual;
		logic [7:0]  pti;
	} xphc_rx_hdr_t;
endpackage
`default_nettype wire

// [xphc_codec.sv]
`timescale 1ns/1ns
`default_nettype none
`include "xphc_defines.svh"
module xphc_codec
(
	input  wire logic                  I_SYS_CLK,
	input  wire logic                  I_RESET,
	input  wire logic [3:0]            I_ADDR,
	input  wire logic [31:0]           I_WDATA,
	input  wire logic                  I_WR,
	input  wire logic                  I_RD,
	output logic [31:0]                O_RDATA,
	input  wire logic                  I_TX_REQ_VALID,
	input  wire xphc_pkg::xphc_tx_req_t I_TX_REQ,
	output logic                       O_TX_REQ_READY,
	input  wire logic                  I_PAY_VALID,
	input  wire xphc_pkg::xphc_byte_t  I_PAY,
	output logic                       O_PAY_READY,
	output logic                       O_LNK_TX_VALID,
	output xphc_pkg::xphc_byte_t       O_LNK_TX,
	input  wire logic                  I_LNK_TX_READY,
	input  wire logic                  I_LNK_RX_VALID,
	input  wire xphc_pkg::xphc_byte_t  I_LNK_RX,
	output logic                       O_RX_EVT,
	output xphc_pkg::xphc_rx_hdr_t     O_RX_HDR,
	output logic                       O_RX_PAY_VALID,
	output xphc_pkg::xphc_byte_t       O_RX_PAY
);
	// Classifies a type octet; data is any even octet, ready/not-ready depend on modulus.
	function automatic xphc_pkg::xphc_kind_t classify(input logic [7:0] p, input logic m128);
		classify = xphc_pkg::K_BAD;
		if (!p[0])
			classify = xphc_pkg::K_DATA;
		else if (m128 ? (p == `XPHC_PTI_RR128) : (p[4:0] == `XPHC_RR8_LOW))
			classify = xphc_pkg::K_RR;
		else if (m128 ? (p == `XPHC_PTI_RNR128) : (p[4:0] == `XPHC_RNR8_LOW))
			classify = xphc_pkg::K_RNR;
		else if (p == `XPHC_PTI_CALL)      classify = xphc_pkg::K_CALL;
		else if (p == `XPHC_PTI_CALL_ACC)  classify = xphc_pkg::K_CALL_ACC;
		else if (p == `XPHC_PTI_CLR)       classify = xphc_pkg::K_CLR;
		else if (p == `XPHC_PTI_CLR_CONF)  classify = xphc_pkg::K_CLR_CONF;
		else if (p == `XPHC_PTI_RST)       classify = xphc_pkg::K_RST;
		else if (p == `XPHC_PTI_RST_CONF)  classify = xphc_pkg::K_RST_CONF;
		else if (p == `XPHC_PTI_RSTRT)     classify = xphc_pkg::K_RSTRT;
		else if (p == `XPHC_PTI_RSTRT_CNF) classify = xphc_pkg::K_RSTRT_CNF;
		else if (p == `XPHC_PTI_DIAG)      classify = xphc_pkg::K_DIAG;
	endfunction

	// Ready, not-ready and data headers grow to four octets under modulo 128.
	function automatic logic [2:0] hdr_len(input xphc_pkg::xphc_kind_t k, input logic m128);
		hdr_len = 3'h3;
		if (m128 && (k == xphc_pkg::K_DATA || k == xphc_pkg::K_RR || k == xphc_pkg::K_RNR))
			hdr_len = 3'h4;
	endfunction

	logic [31:0]              ctrl_q;
	logic [7:0]               stat_q;
	logic [7:0]               last_pti_q;
	logic [15:0]              rxcnt_q;
	logic                     mod128;
	logic [1:0]               llc;
	logic                     svc;
	logic [11:0]              act_lci;

	assign mod128  = ctrl_q[`XPHC_CTRL_MOD128];
	assign llc     = ctrl_q[`XPHC_CTRL_LLC_LO +: 2];
	assign svc     = ctrl_q[`XPHC_CTRL_SVC];
	assign act_lci = ctrl_q[`XPHC_CTRL_LCI_LO +: 12];

	// Receive side: octets are counted and the header fields captured as they pass.
	logic [2:0]               rx_idx_q;
	logic [7:0]               rx_b0_q;
	logic [7:0]               rx_b1_q;
	logic [7:0]               rx_b2_q;
	logic [7:0]               rx_b3_q;
	logic                     rx_dbit_q;
	logic                     rx_take;
	logic                     rx_end;
	logic [7:0]               rx_pti;
	logic [7:0]               rx_b3;
	xphc_pkg::xphc_kind_t     rx_kind;
	logic [11:0]              rx_lci;
	logic [2:0]               rx_hlen;
	logic                     rx_gfi_bad;
	logic                     rx_lci_bad;
	logic                     rx_short;
	logic                     rx_extra;
	logic                     rx_type_bad;
	logic                     rx_ok;
	logic                     rx_fwd;

	assign rx_take    = I_LNK_RX_VALID;
	assign rx_end     = rx_take && I_LNK_RX.last;
	assign rx_pti     = (rx_idx_q == 3'h2) ? I_LNK_RX.data : rx_b2_q;
	assign rx_b3      = (rx_idx_q == 3'h3) ? I_LNK_RX.data : rx_b3_q;
	assign rx_kind    = classify(rx_pti, mod128);
	assign rx_lci     = {rx_b0_q[3:0], rx_b1_q};
	assign rx_hlen    = hdr_len(rx_kind, mod128);
	assign rx_gfi_bad = rx_b0_q[`XPHC_GFI_M128] != mod128 || rx_b0_q[`XPHC_GFI_M8] == mod128;
	assign rx_lci_bad = rx_lci == `XPHC_LCI_NONE || rx_lci != act_lci;
	assign rx_short   = rx_idx_q < rx_hlen - 3'h1;
	assign rx_extra   = (rx_kind == xphc_pkg::K_RR || rx_kind == xphc_pkg::K_RNR)
	                    && rx_idx_q >= rx_hlen;
	assign rx_type_bad = rx_kind == xphc_pkg::K_BAD || rx_gfi_bad || rx_extra;
	assign rx_ok      = !rx_short && !rx_type_bad && !rx_lci_bad && !rx_dbit_q;
	// Payload is only forwarded once the header is known good, so dropped packets leak no payload octets.
	assign rx_fwd     = rx_take && rx_kind == xphc_pkg::K_DATA && rx_idx_q >= rx_hlen
	                    && !rx_type_bad && !rx_lci_bad && !rx_dbit_q;

	// Octet capture; the index saturates since only the first four octets matter.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET || rx_end)
			rx_idx_q <= 3'h0;
		else if (rx_take && rx_idx_q != 3'h7)
			rx_idx_q <= rx_idx_q + 3'h1;
		if (rx_take && rx_idx_q == 3'h0)
			rx_b0_q <= I_LNK_RX.data;
		if (rx_take && rx_idx_q == 3'h1)
			rx_b1_q <= I_LNK_RX.data;
		if (rx_take && rx_idx_q == 3'h2)
			rx_b2_q <= I_LNK_RX.data;
		if (rx_take && rx_idx_q == 3'h3)
			rx_b3_q <= I_LNK_RX.data;
	end

	// A packet already carrying a confirmation request is marked from its first octet.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET || rx_end)
			rx_dbit_q <= 1'b0;
		else if (rx_take && rx_idx_q == 3'h0)
			rx_dbit_q <= I_LNK_RX.data[`XPHC_GFI_D];
	end

	// Received header event and payload, all from flops.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			O_RX_EVT       <= 1'b0;
			O_RX_PAY_VALID <= 1'b0;
			O_RX_HDR       <= '0;
			O_RX_PAY       <= '0;
		end
		else
		begin
			O_RX_EVT       <= rx_end && rx_ok;
			O_RX_PAY_VALID <= rx_fwd;
			if (rx_fwd)
				O_RX_PAY <= I_LNK_RX;
			if (rx_end)
			begin
				O_RX_HDR.kind <= rx_kind;
				O_RX_HDR.lci  <= rx_lci;
				O_RX_HDR.pti  <= rx_pti;
				O_RX_HDR.qual <= rx_b0_q[`XPHC_GFI_Q];
				O_RX_HDR.ps   <= mod128 ? rx_pti[7:1] : {4'h0, rx_pti[3:1]};
				O_RX_HDR.more <= mod128 ? rx_b3[0] : rx_pti[4];
				O_RX_HDR.pr   <= mod128 ? rx_b3[7:1] : {4'h0, rx_pti[7:5]};
			end
		end
	end

	// Transmit side.
	xphc_pkg::xphc_state_t    st_q;
	xphc_pkg::xphc_tx_req_t   req_q;
	xphc_pkg::xphc_tx_req_t   auto_req;
	logic [2:0]               tx_idx_q;
	logic                     resp_pend_q;
	logic                     out_adv;
	logic                     req_take;
	logic                     req_refuse;
	logic                     start_auto;
	logic                     has_cause;
	logic                     has_pay;
	logic [2:0]               tx_len;
	logic                     tx_last_hdr;
	logic [7:0]               tx_pti;
	logic [7:0]               tx_b0;
	logic [7:0]               tx_b3;
	logic [7:0]               tx_byte;
	logic                     pay_take;

	// The answer to a confirmation request takes the form matching the circuit kind.
	assign auto_req   = '{kind: svc ? xphc_pkg::K_CLR : xphc_pkg::K_RST, ps: 7'h00, pr: 7'h00,
	                      more: 1'b0, qual: 1'b0, cause: 8'h00, diag: `XPHC_DIAG_BAD_DBIT};
	assign out_adv    = !O_LNK_TX_VALID || I_LNK_TX_READY;
	assign start_auto = st_q == xphc_pkg::S_IDLE && resp_pend_q;
	assign O_TX_REQ_READY = st_q == xphc_pkg::S_IDLE && !resp_pend_q;
	assign req_take   = O_TX_REQ_READY && I_TX_REQ_VALID;
	assign req_refuse = req_take && (I_TX_REQ.kind == xphc_pkg::K_RNR
	                    || I_TX_REQ.kind == xphc_pkg::K_BAD
	                    || act_lci == `XPHC_LCI_NONE);
	assign has_cause  = req_q.kind == xphc_pkg::K_CLR || req_q.kind == xphc_pkg::K_RST
	                    || req_q.kind == xphc_pkg::K_RSTRT;
	assign has_pay    = req_q.kind == xphc_pkg::K_DATA || req_q.kind == xphc_pkg::K_CALL
	                    || req_q.kind == xphc_pkg::K_CALL_ACC;
	assign tx_len     = has_cause ? 3'h5 : hdr_len(req_q.kind, mod128);
	assign tx_last_hdr = tx_idx_q == tx_len - 3'h1;

	// Octet 0: qualifier only for qualified data, confirmation never asked, one modulus bit.
	assign tx_b0 = {llc == `XPHC_LLC_QUAL && req_q.kind == xphc_pkg::K_DATA && req_q.qual,
	                1'b0,
	                mod128, !mod128,
	                act_lci[11:8]};

	// Type octet per kind and modulus.
	always_comb
	begin
		tx_pti = `XPHC_PTI_DIAG;
		unique case (req_q.kind)
			xphc_pkg::K_DATA:      tx_pti = mod128 ? {req_q.ps, 1'b0}
			                       : {req_q.pr[2:0], req_q.more, req_q.ps[2:0], 1'b0};
			xphc_pkg::K_RR:        tx_pti = mod128 ? `XPHC_PTI_RR128
			                       : {req_q.pr[2:0], `XPHC_RR8_LOW};
			xphc_pkg::K_CALL:      tx_pti = `XPHC_PTI_CALL;
			xphc_pkg::K_CALL_ACC:  tx_pti = `XPHC_PTI_CALL_ACC;
			xphc_pkg::K_CLR:       tx_pti = `XPHC_PTI_CLR;
			xphc_pkg::K_CLR_CONF:  tx_pti = `XPHC_PTI_CLR_CONF;
			xphc_pkg::K_RST:       tx_pti = `XPHC_PTI_RST;
			xphc_pkg::K_RST_CONF:  tx_pti = `XPHC_PTI_RST_CONF;
			xphc_pkg::K_RSTRT:     tx_pti = `XPHC_PTI_RSTRT;
			xphc_pkg::K_RSTRT_CNF: tx_pti = `XPHC_PTI_RSTRT_CNF;
			default:               tx_pti = `XPHC_PTI_DIAG;
		endcase
	end

	assign tx_b3 = has_cause ? req_q.cause
	               : {req_q.pr, req_q.kind == xphc_pkg::K_DATA && req_q.more};
	assign tx_byte = tx_idx_q == 3'h0 ? tx_b0
	               : tx_idx_q == 3'h1 ? act_lci[7:0]
	               : tx_idx_q == 3'h2 ? tx_pti
	               : tx_idx_q == 3'h3 ? tx_b3 : req_q.diag;
	assign O_PAY_READY = st_q == xphc_pkg::S_PAY && out_adv;
	assign pay_take    = O_PAY_READY && I_PAY_VALID;

	// Sequencer: idle, header octets, then payload for kinds that carry one.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			st_q     <= xphc_pkg::S_IDLE;
			tx_idx_q <= 3'h0;
			req_q    <= '0;
		end
		else
		begin
			unique case (st_q)
				xphc_pkg::S_IDLE:
				begin
					tx_idx_q <= 3'h0;
					if (start_auto)
					begin
						req_q <= auto_req;
						st_q  <= xphc_pkg::S_HDR;
					end
					else if (req_take && !req_refuse)
					begin
						req_q <= I_TX_REQ;
						st_q  <= xphc_pkg::S_HDR;
					end
				end
				xphc_pkg::S_HDR:
					if (out_adv)
					begin
						tx_idx_q <= tx_idx_q + 3'h1;
						if (tx_last_hdr)
							st_q <= has_pay ? xphc_pkg::S_PAY : xphc_pkg::S_IDLE;
					end
				xphc_pkg::S_PAY:
					if (pay_take && I_PAY.last)
						st_q <= xphc_pkg::S_IDLE;
				default:
					st_q <= xphc_pkg::S_IDLE;
			endcase
		end
	end

	// Link output register; the whole packet goes to the link layer as one frame payload.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			O_LNK_TX_VALID <= 1'b0;
			O_LNK_TX       <= '0;
		end
		else if (out_adv)
		begin
			O_LNK_TX_VALID <= st_q == xphc_pkg::S_HDR || pay_take;
			if (st_q == xphc_pkg::S_HDR)
				O_LNK_TX <= '{data: tx_byte, last: tx_last_hdr && !has_pay};
			else if (pay_take)
				O_LNK_TX <= I_PAY;
		end
	end

	// Pending answer: a new offending packet re-arms it even as the answer starts.
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
			resp_pend_q <= 1'b0;
		else if (rx_end && rx_dbit_q)
			resp_pend_q <= 1'b1;
		else if (start_auto)
			resp_pend_q <= 1'b0;
	end

	// Register bus. Status bits are sticky, write one to clear, and a new event beats the clear.
	logic [7:0]               stat_set;
	logic                     wr_ctrl;
	logic                     wr_stat;
	logic [31:0]              rd_mux;

	assign stat_set = {3'h0, req_refuse, rx_end && rx_short, rx_end && rx_lci_bad && !rx_short,
	                   rx_end && rx_type_bad && !rx_short, rx_end && rx_dbit_q};
	assign wr_ctrl  = I_WR && I_ADDR == `XPHC_ADDR_CTRL;
	assign wr_stat  = I_WR && I_ADDR == `XPHC_ADDR_STAT;
	assign rd_mux   = I_ADDR == `XPHC_ADDR_CTRL  ? {4'h0, act_lci, 12'h000, svc, llc, mod128}
	                : I_ADDR == `XPHC_ADDR_STAT  ? {16'h0000, last_pti_q, stat_q}
	                : I_ADDR == `XPHC_ADDR_RXCNT ? {16'h0000, rxcnt_q} : 32'h0000_0000;

	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_RESET)
		begin
			ctrl_q     <= 32'h0000_0000;
			stat_q     <= 8'h00;
			last_pti_q <= 8'h00;
			rxcnt_q    <= 16'h0000;
			O_RDATA    <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= {4'h0, I_WDATA[27:16], 12'h000, I_WDATA[3:0]};
			stat_q <= (stat_q & ~(wr_stat ? I_WDATA[7:0] : 8'h00)) | stat_set;
			if (rx_end)
				last_pti_q <= rx_pti;
			if (rx_end && rx_ok)
				rxcnt_q <= rxcnt_q + 16'h0001;
			O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
		end
	end

	// Checks.
	a_dbit_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(O_LNK_TX_VALID && st_q != xphc_pkg::S_IDLE && tx_idx_q == 3'h1)
		|-> !O_LNK_TX.data[`XPHC_GFI_D]) else $error("confirmation bit sent");
	a_mod_bits: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(O_LNK_TX_VALID && st_q != xphc_pkg::S_IDLE && tx_idx_q == 3'h1)
		|-> O_LNK_TX.data[`XPHC_GFI_M128] != O_LNK_TX.data[`XPHC_GFI_M8])
		else $error("modulus bits clash");
	a_qual_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(llc != `XPHC_LLC_QUAL && O_LNK_TX_VALID && st_q != xphc_pkg::S_IDLE
		 && tx_idx_q == 3'h1) |-> !O_LNK_TX.data[`XPHC_GFI_Q]) else $error("qualifier set");
	a_dbit_answer: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(rx_end && rx_dbit_q) |=> resp_pend_q || start_auto) else $error("no answer armed");
	a_no_rnr_tx: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(st_q != xphc_pkg::S_IDLE) |-> req_q.kind != xphc_pkg::K_RNR) else $error("rnr sent");
	a_lci_drop: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(rx_end && rx_lci == `XPHC_LCI_NONE) |=> !O_RX_EVT && stat_q != 8'h00)
		else $error("channel zero accepted");
	a_min_len: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(st_q == xphc_pkg::S_HDR && out_adv && tx_last_hdr) |-> tx_idx_q >= 3'h2)
		else $error("header too short");
	a_rr_nodata: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		(rx_take && (rx_kind == xphc_pkg::K_RR || rx_kind == xphc_pkg::K_RNR)) |=> !O_RX_PAY_VALID)
		else $error("ready packet payload");
	a_auto_diag: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
		start_auto |=> req_q.diag == `XPHC_DIAG_BAD_DBIT ##0 st_q == xphc_pkg::S_HDR)
		else $error("wrong diagnostic");
endmodule
`default_nettype wire

// [xphc_dce_model.sv]
`timescale 1ns/1ns
`default_nettype none
module xphc_dce_model
(
	input  wire logic                 i_clk,
	input  wire logic                 i_tx_valid,
	input  wire xphc_pkg::xphc_byte_t i_tx,
	output logic                      o_tx_ready,
	output logic                      o_rx_valid,
	output xphc_pkg::xphc_byte_t      o_rx
);
	logic [7:0] got[$];
	logic       got_end = 1'b0;
	logic       slow = 1'b0;

	// The network starts idle and ready to take octets.
	initial
	begin
		o_tx_ready = 1'b1;
		o_rx_valid = 1'b0;
		o_rx = '0;
	end

	// Octets are collected until the last one; a slow network drops ready at random,
	// so the codec has to hold every octet until it is taken.
	always @(posedge i_clk)
	begin
		if (i_tx_valid && o_tx_ready)
		begin
			got.push_back(i_tx.data);
			got_end <= i_tx.last;
		end
		o_tx_ready <= !slow || $urandom_range(1) == 1;
	end

	// Each packet's octets go out back to back; between packets valid drops and the data lines show the inverse
	// of the last octet, since nothing meaningful is driven there.
	task automatic send(input logic [7:0] p[$]);
		foreach (p[i])
		begin
			@(posedge i_clk);
			o_rx_valid <= 1'b1;
			o_rx.data <= p[i];
			o_rx.last <= i == p.size() - 1;
		end
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx.data <= ~o_rx.data;
	endtask
endmodule
`default_nettype wire

// [tb_x25_packet_header_codec.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_x25_packet_header_codec;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, req_v = 1'b0, pay_v = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic req_rdy, pay_rdy, ltx_v, ltx_rdy, lrx_v, evt, rp_v, m128;
	logic [1:0] llc;
	logic [11:0] lci;
	xphc_pkg::xphc_tx_req_t req = '0;
	xphc_pkg::xphc_byte_t pay = '0, ltx, lrx, rp;
	xphc_pkg::xphc_rx_hdr_t hdr, hq;
	logic [7:0] ex[$], pl[$], rxp[$];
	logic [7:0] ptab[3:11] = '{8'h0B, 8'h0F, 8'h13, 8'h17, 8'h1B, 8'h1F, 8'hFB, 8'hFF, 8'hF1};
	int errors = 0, n_compared = 0, n_evt = 0;

	always #5 clk = ~clk;

	xphc_codec DUT (.I_SYS_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TX_REQ_VALID(req_v), .I_TX_REQ(req),
		.O_TX_REQ_READY(req_rdy), .I_PAY_VALID(pay_v), .I_PAY(pay), .O_PAY_READY(pay_rdy),
		.O_LNK_TX_VALID(ltx_v), .O_LNK_TX(ltx), .I_LNK_TX_READY(ltx_rdy),
		.I_LNK_RX_VALID(lrx_v), .I_LNK_RX(lrx), .O_RX_EVT(evt), .O_RX_HDR(hdr),
		.O_RX_PAY_VALID(rp_v), .O_RX_PAY(rp));
	xphc_dce_model DCE (.i_clk(clk), .i_tx_valid(ltx_v), .i_tx(ltx), .o_tx_ready(ltx_rdy),
		.o_rx_valid(lrx_v), .o_rx(lrx));

	// Received events and payload are registered, so reading them at the edge is safe.
	always @(posedge clk)
	begin
		if (evt === 1'b1)
		begin
			n_evt++;
			hq = hdr;
		end
		if (rp_v === 1'b1)
			rxp.push_back(rp.data);
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] want, input string what);
		n_compared++;
		if (got !== want)
		begin
			errors++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, want);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic cfg(input logic m, input logic [1:0] l, input logic s, input logic [11:0] c);
		m128 = m;
		llc = l;
		lci = c;
		wreg(4'h0, {4'h0, c, 12'h000, s, l, m});
	endtask

	// Expected octets of a transmitted packet, from the configured modulus and channel.
	function automatic void build(input xphc_pkg::xphc_tx_req_t r);
		logic d, rr;
		d = r.kind == 4'h0;
		rr = r.kind == 4'h1;
		ex = '{{d && llc == 2'h0 && r.qual, 1'b0, m128, !m128, lci[11:8]}, lci[7:0]};
		ex.push_back(d ? (m128 ? {r.ps, 1'b0} : {r.pr[2:0], r.more, r.ps[2:0], 1'b0})
			: rr ? (m128 ? 8'h01 : {r.pr[2:0], 5'h01}) : ptab[r.kind]);
		if (m128 && (d || rr))
			ex.push_back({r.pr, d & r.more});
		if (r.kind inside {4'h5, 4'h7, 4'h9})
			ex = {ex, r.cause, r.diag};
		if (r.kind inside {4'h0, 4'h3, 4'h4})
			ex = {ex, pl};
	endfunction

	// A stuck codec ends the wait after a bounded number of cycles; the compare then fails.
	task automatic waitf();
		int n = 0;
		while (DCE.got_end !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic cmpf();
		chk(DCE.got.size(), ex.size(), "frame length");
		foreach (ex[i])
			chk(DCE.got[i], ex[i], "frame octet");
	endtask

	// Request and payload are held until the edge where ready is seen high.
	task automatic run(input xphc_pkg::xphc_tx_req_t r, input logic ok);
		logic [31:0] s;
		pl.delete();
		repeat (1 + $urandom_range(2))
			pl.push_back(8'($urandom));
		build(r);
		DCE.got.delete();
		DCE.got_end = 1'b0;
		@(posedge clk);
		req_v <= 1'b1;
		req <= r;
		do @(negedge clk); while (req_rdy !== 1'b1);
		@(posedge clk);
		req_v <= 1'b0;
		req <= ~r;
		if (ok && r.kind inside {4'h0, 4'h3, 4'h4})
			foreach (pl[i])
			begin
				pay_v <= 1'b1;
				pay.data <= pl[i];
				pay.last <= i == pl.size() - 1;
				do @(negedge clk); while (pay_rdy !== 1'b1);
				@(posedge clk);
			end
		pay_v <= 1'b0;
		pay.data <= ~pay.data;
		waitf();
		if (ok)
			cmpf();
		else
		begin
			chk(DCE.got.size(), 0, "refused request sent");
			rreg(4'h4, s);
			chk(s[4], 1, "refusal flag");
			wreg(4'h4, 32'h1F);
		end
	endtask

	task automatic rx(input logic [7:0] p[$], input int sb);
		int e0;
		logic [31:0] s;
		e0 = n_evt;
		rxp.delete();
		DCE.got.delete();
		DCE.got_end = 1'b0;
		DCE.send(p);
		repeat (2) @(posedge clk);
		chk(n_evt - e0, sb < 0, "event count");
		rreg(4'h4, s);
		chk(sb < 0 ? s[3:0] : s[sb], sb >= 0, "status");
		wreg(4'h4, 32'h1F);
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// About 2500 cycles are expected; the limit allows roughly twenty times that.
	initial
	begin
		#500000;
		errors++;
		print_verdict();
	end

	initial
	begin
		xphc_pkg::xphc_tx_req_t r;
		logic [31:0] v;
		logic [7:0] g;
		logic [6:0] pr;
		void'($urandom(12));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk(req_rdy, 1, "ready after reset");
		for (int a = 0; a < 16; a += 4)
		begin
			rreg(a[3:0], v);
			chk(v, 0, "register reset value");
		end
		// Every kind under both moduli and all link controls; the not-ready kind is refused.
		for (int i = 0; i < 6; i++)
		begin
			cfg(i[0], i[2:1], 1'b1, 12'(1 + $urandom_range(4094)));
			DCE.slow = i[1];
			for (int k = 0; k < 12; k++)
			begin
				{r.ps, r.pr, r.more, r.qual, r.cause, r.diag} = $urandom;
				r.kind = xphc_pkg::xphc_kind_t'(k);
				run(r, k != 2);
			end
		end
		r.kind = xphc_pkg::K_BAD;
		run(r, 1'b0);
		cfg(1'b0, 2'h0, 1'b0, 12'h000);
		r.kind = xphc_pkg::K_RR;
		run(r, 1'b0);
		$display("transmit tests done");
		cfg(1'b1, 2'h1, 1'b0, 12'(1 + $urandom_range(4094)));
		g = {4'h2, lci[11:8]};
		pr = 7'($urandom);
		rx('{g, lci[7:0], 8'h01, {pr, 1'b0}}, -1);
		chk({hq.kind, hq.lci, hq.pr}, {4'h1, lci, pr}, "ready header");
		rx('{g, lci[7:0], 8'h05, {pr, 1'b0}}, -1);
		chk({hq.kind, hq.pr}, {4'h2, pr}, "not ready header");
		rx('{g, lci[7:0], {pr, 1'b0}, {~pr, 1'b1}, 8'hA5, 8'h3C}, -1);
		chk({hq.kind, hq.ps, hq.pr, hq.more}, {4'h0, pr, ~pr, 1'b1}, "data header");
		chk({rxp[0], rxp[1], rxp.size()}, {8'hA5, 8'h3C, 32'h2}, "data payload");
		rx('{g, lci[7:0] ^ 8'h01, 8'h01, 8'h00}, 2);
		rx('{8'h20, 8'h00, 8'h01, 8'h00}, 2);
		rx('{g, lci[7:0], 8'h07, 8'h00}, 1);
		rx('{g, lci[7:0], 8'h01, 8'h00, 8'h5A}, 1);
		rx('{g ^ 8'h30, lci[7:0], 8'h01, 8'h00}, 1);
		rx('{g, lci[7:0]}, 3);
		rx('{g | 8'h40, lci[7:0], 8'h01, 8'h00}, 0);
		r = '0;
		r.kind = xphc_pkg::K_RST;
		r.diag = 8'hE9;
		build(r);
		waitf();
		cmpf();
		cfg(1'b0, 2'h0, 1'b1, lci);
		g = {4'h1, lci[11:8]};
		rx('{g | 8'h40, lci[7:0], 8'h21}, 0);
		r.kind = xphc_pkg::K_CLR;
		build(r);
		waitf();
		cmpf();
		rx('{g, lci[7:0], {pr[2:0], 5'h05}}, -1);
		chk({hq.kind, hq.pr[2:0]}, {4'h2, pr[2:0]}, "modulo 8 not ready header");
		rreg(4'h8, v);
		chk(v, 4, "good packet count");
		$display("receive tests done");
		print_verdict();
	end
endmodule
`default_nettype wire
